// [shared/dmsc_pkg.sv]
package dmsc_pkg;
  // ==========================================================
  // Widths and timing
  localparam int POS_W         = 16;
  localparam int CLK_HZ        = 25_000_000;
  localparam int TEACH_WIN_MS  = 1000;
  localparam int TEACH_WIN_CYC = CLK_HZ / 1000 * TEACH_WIN_MS;
  localparam int MS_CYC        = CLK_HZ / 1000;
  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_HOLD   = 8'h04;
  localparam logic [7:0] OFS_PWIDTH = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam int CTRL_TEACH_DIS = 0;
  localparam int FLAG_TAUGHT    = 0;
  localparam int FLAG_MISSED    = 1;
  localparam int STAT_POS_LSB   = 0;
  localparam int STAT_STATE_LSB = 16;
  localparam int STAT_MODE_LSB  = 20;
  localparam logic [15:0]      HOLD_RST   = 16'h0BB8;
  localparam logic [POS_W-1:0] PWIDTH_RST = 16'h8000;
  localparam logic [POS_W-1:0] FULL_POS   = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Panel encodings and types
  localparam logic [1:0] SEL_AUTO  = 2'h0;
  localparam logic [1:0] SEL_CLOSE = 2'h1;
  localparam logic [1:0] SEL_OPEN  = 2'h2;
  typedef enum logic [1:0] {MODE_AUTO, MODE_CLOSED, MODE_OPEN} dmsc_mode_t;
  typedef enum logic [2:0] {ST_CLOSED, ST_OPENING, ST_HOLD, ST_CLOSING, ST_TEACH_STOP}
    dmsc_state_t;
  typedef struct packed {
    logic [1:0] main_sel;
    logic       exit_only;
    logic       partial;
    logic       present;
  } dmsc_panel_t;
  typedef struct packed {
    logic act_int;
    logic act_ext;
    logic presence;
    logic beam;
    logic at_closed;
    logic at_open;
  } dmsc_sense_t;
  typedef struct packed {
    logic open;
    logic close;
    logic creep;
    logic stop;
  } dmsc_cmd_t;
endpackage

// [src/dmsc_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module dmsc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // ==========================================================
  // Two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// [src/dmsc_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module dmsc_timer #(
  parameter int W   = 25,
  parameter int LEN = 25_000_000
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic start,
  input  wire logic cancel,
  // Status
  output var  logic running,
  output var  logic expired
);
  logic [W-1:0] cnt_reg;

  if (LEN < 1 || LEN >= (2 ** W)) begin : g_chk
    $error("dmsc_timer: LEN does not fit W");
  end

  // ==========================================================
  // One-shot window; cancel wins over start
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cancel)
    begin
      cnt_reg <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else if (start)
    begin
      cnt_reg <= W'(LEN - 1);
      running <= 1'b1;
      expired <= 1'b0;
    end
    else if (running && cnt_reg == '0)
    begin
      running <= 1'b0;
      expired <= 1'b1;
    end
    else
    begin
      cnt_reg <= running ? cnt_reg - 1'b1 : cnt_reg;
      expired <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [src/dmsc_top.sv]
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module dmsc_top #(
  parameter int TEACH_WIN_CYC = dmsc_pkg::TEACH_WIN_CYC,
  parameter int MS_CYC        = dmsc_pkg::MS_CYC
) (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output var  logic                       s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output var  logic                       s_axi_wready,
  output var  logic [1:0]                 s_axi_bresp,
  output var  logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output var  logic                       s_axi_arready,
  output var  logic [31:0]                s_axi_rdata,
  output var  logic [1:0]                 s_axi_rresp,
  output var  logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Panel and sensor pins
  input  wire dmsc_pkg::dmsc_panel_t      panel_pin,
  input  wire dmsc_pkg::dmsc_sense_t      sense_pin,
  // Door position from drive logic
  input  wire logic [dmsc_pkg::POS_W-1:0] door_pos,
  // Drive commands
  output var  dmsc_pkg::dmsc_cmd_t        drive_cmd,
  output var  logic [dmsc_pkg::POS_W-1:0] drive_target
);
  localparam int PW    = dmsc_pkg::POS_W;
  localparam int PIN_W = $bits(dmsc_pkg::dmsc_panel_t) + $bits(dmsc_pkg::dmsc_sense_t);

  if (MS_CYC < 1 || MS_CYC >= (2 ** 16)) begin : g_chk_ms
    $error("dmsc_top: MS_CYC out of range");
  end

  // ==========================================================
  // Helpers
  function automatic dmsc_pkg::dmsc_mode_t decode_mode(input dmsc_pkg::dmsc_panel_t p);
    dmsc_pkg::dmsc_mode_t m;
    m = dmsc_pkg::MODE_CLOSED;
    if (p.present)
    begin
      case (p.main_sel)
        dmsc_pkg::SEL_AUTO: m = dmsc_pkg::MODE_AUTO;
        dmsc_pkg::SEL_OPEN: m = dmsc_pkg::MODE_OPEN;
        default:            m = dmsc_pkg::MODE_CLOSED;
      endcase
    end
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // ==========================================================
  // Pin synchronisation
  dmsc_pkg::dmsc_panel_t panel_s;
  dmsc_pkg::dmsc_sense_t sense_s;
  logic [PIN_W-1:0]      pins_s;

  dmsc_sync #(.W(PIN_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({panel_pin, sense_pin}),
    .q       (pins_s)
  );
  assign {panel_s, sense_s} = pins_s;

  // ==========================================================
  // Registers and state
  dmsc_pkg::dmsc_mode_t  mode;
  dmsc_pkg::dmsc_state_t state_reg;
  logic [31:0]    ctrl_reg;
  logic [15:0]    hold_ms_reg;
  logic [PW-1:0]  pwidth_reg;
  logic [1:0]     flags_reg;
  logic [7:0]     waddr_reg;
  logic [31:0]    wdata_reg;
  logic [3:0]     wstrb_reg;
  logic [31:0]    ctrl_wr;
  logic [31:0]    hold_wr;
  logic [31:0]    pwidth_wr;
  logic           do_write;
  logic [31:0]    rd_val;
  logic           rd_err;
  logic           activate;
  logic           busy;
  logic           reached;
  logic [PW-1:0]  target;
  logic [15:0]    pre_reg;
  logic [15:0]    held_ms_reg;
  logic           hold_done;
  logic           armed_reg;
  logic           partial_q_reg;
  logic           auto_q_reg;
  logic           part_first_reg;
  logic           cap_valid_reg;
  logic [PW-1:0]  cap_reg;
  logic           partial_rise;
  logic           auto_rise;
  logic           commit;
  logic           first_evt;
  logic           win_run;
  logic           win_exp;
  logic           disarm;

  assign mode = decode_mode(panel_s);
  // External sensor is blocked only while fully closed in one-direction mode
  assign activate = sense_s.act_int |
                    (sense_s.act_ext & ~(panel_s.exit_only & sense_s.at_closed));
  assign busy = activate | sense_s.presence | sense_s.beam;
  // Open mode always goes full width; auto honours the reduced width
  assign target = (mode == dmsc_pkg::MODE_AUTO && panel_s.partial) ? pwidth_reg
                : dmsc_pkg::FULL_POS;
  assign reached = sense_s.at_open | (door_pos >= target);

  // ==========================================================
  // AXI4-Lite write path
  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  // Byte-lane merge of the pending write into each register's current value
  assign ctrl_wr   = merge(ctrl_reg, wdata_reg, wstrb_reg);
  assign hold_wr   = merge({16'h0000, hold_ms_reg}, wdata_reg, wstrb_reg);
  assign pwidth_wr = merge({16'h0000, pwidth_reg}, wdata_reg, wstrb_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= dmsc_pkg::RESP_OKAY;
      waddr_reg     <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
    end
    else
    begin
      if (s_axi_awready && s_axi_awvalid)
      begin
        s_axi_awready <= 1'b0;
        waddr_reg     <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        s_axi_wready <= 1'b0;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        case (waddr_reg)
          dmsc_pkg::OFS_CTRL, dmsc_pkg::OFS_HOLD, dmsc_pkg::OFS_PWIDTH,
          dmsc_pkg::OFS_STATUS, dmsc_pkg::OFS_FLAGS: s_axi_bresp <= dmsc_pkg::RESP_OKAY;
          default: s_axi_bresp <= dmsc_pkg::RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg    <= 32'h00000000;
      hold_ms_reg <= dmsc_pkg::HOLD_RST;
    end
    else if (do_write && waddr_reg == dmsc_pkg::OFS_CTRL)
      ctrl_reg <= {31'h00000000, ctrl_wr[0]};
    else if (do_write && waddr_reg == dmsc_pkg::OFS_HOLD)
      hold_ms_reg <= hold_wr[15:0];
  end

  // Teach capture wins over a bus write in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwidth_reg <= dmsc_pkg::PWIDTH_RST;
    else if (commit)
      pwidth_reg <= auto_rise ? door_pos : cap_reg;
    else if (do_write && waddr_reg == dmsc_pkg::OFS_PWIDTH)
      pwidth_reg <= pwidth_wr[PW-1:0];
  end

  // Sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_reg <= 2'h0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == dmsc_pkg::FLAG_TAUGHT) ? commit : win_exp)
          flags_reg[i] <= 1'b1;
        else if (do_write && waddr_reg == dmsc_pkg::OFS_FLAGS && wstrb_reg[0] && wdata_reg[i])
          flags_reg[i] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  always_comb
  begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    case (s_axi_araddr)
      dmsc_pkg::OFS_CTRL:   rd_val = ctrl_reg;
      dmsc_pkg::OFS_HOLD:   rd_val = {16'h0000, hold_ms_reg};
      dmsc_pkg::OFS_PWIDTH: rd_val = {16'h0000, pwidth_reg};
      dmsc_pkg::OFS_FLAGS:  rd_val = {30'h00000000, flags_reg};
      dmsc_pkg::OFS_STATUS:
      begin
        rd_val[dmsc_pkg::STAT_POS_LSB +: PW]  = door_pos;
        rd_val[dmsc_pkg::STAT_STATE_LSB +: 3] = state_reg;
        rd_val[dmsc_pkg::STAT_MODE_LSB +: 2]  = mode;
      end
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= dmsc_pkg::RESP_OKAY;
    end
    else if (s_axi_arready && s_axi_arvalid)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_err ? dmsc_pkg::RESP_SLVERR : dmsc_pkg::RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ==========================================================
  // Hold-open timer, restarted by any sensor activity
  assign hold_done = held_ms_reg >= hold_ms_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || state_reg != dmsc_pkg::ST_HOLD || busy)
    begin
      pre_reg     <= 16'h0000;
      held_ms_reg <= 16'h0000;
    end
    else if (pre_reg == 16'(MS_CYC - 1))
    begin
      pre_reg     <= 16'h0000;
      held_ms_reg <= hold_done ? held_ms_reg : held_ms_reg + 1'b1;
    end
    else
      pre_reg <= pre_reg + 1'b1;
  end

  // ==========================================================
  // Panel teaching of the partial width
  assign partial_rise = panel_s.partial & ~partial_q_reg;
  assign auto_rise    = (mode == dmsc_pkg::MODE_AUTO) & ~auto_q_reg;
  // Both changes inside one window, or both in one cycle
  assign commit = armed_reg & ((auto_rise & (partial_rise | (win_run & part_first_reg))) |
                  (partial_rise & win_run & cap_valid_reg));
  assign first_evt = armed_reg & ~win_run & ~commit & (partial_rise | auto_rise);
  // A missed window drops the attempt and sets the missed flag
  assign disarm = commit | win_exp | (mode == dmsc_pkg::MODE_CLOSED);

  dmsc_timer #(.W(25), .LEN(TEACH_WIN_CYC)) u_win (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (first_evt),
    .cancel  (disarm & ~win_exp),
    .running (win_run),
    .expired (win_exp)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      armed_reg      <= 1'b0;
      partial_q_reg  <= 1'b0;
      auto_q_reg     <= 1'b0;
      part_first_reg <= 1'b0;
      cap_valid_reg  <= 1'b0;
      cap_reg        <= '0;
    end
    else
    begin
      partial_q_reg <= panel_s.partial;
      auto_q_reg    <= (mode == dmsc_pkg::MODE_AUTO);
      if (disarm)
      begin
        armed_reg      <= 1'b0;
        part_first_reg <= 1'b0;
        cap_valid_reg  <= 1'b0;
      end
      // Arm only when a creep opening starts from closed with reduced width off
      else if (state_reg == dmsc_pkg::ST_CLOSED && mode == dmsc_pkg::MODE_OPEN &&
               !panel_s.partial && !ctrl_reg[dmsc_pkg::CTRL_TEACH_DIS])
        armed_reg <= 1'b1;
      else if (first_evt)
      begin
        part_first_reg <= partial_rise;
        cap_valid_reg  <= auto_rise;
        cap_reg        <= door_pos;
      end
    end
  end

  // ==========================================================
  // Door sequencing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= dmsc_pkg::ST_CLOSED;
    else if (commit)
      state_reg <= dmsc_pkg::ST_TEACH_STOP;
    else
    begin
      case (state_reg)
        dmsc_pkg::ST_CLOSED:
          if (mode == dmsc_pkg::MODE_OPEN || (mode == dmsc_pkg::MODE_AUTO && activate))
            state_reg <= dmsc_pkg::ST_OPENING;
        dmsc_pkg::ST_OPENING:
          if (mode == dmsc_pkg::MODE_CLOSED)
            state_reg <= dmsc_pkg::ST_CLOSING;
          else if (reached)
            state_reg <= dmsc_pkg::ST_HOLD;
        dmsc_pkg::ST_HOLD:
          if (mode == dmsc_pkg::MODE_CLOSED)
            state_reg <= dmsc_pkg::ST_CLOSING;
          else if (mode == dmsc_pkg::MODE_AUTO && !reached)
            state_reg <= dmsc_pkg::ST_OPENING;
          else if (mode == dmsc_pkg::MODE_AUTO && !busy && hold_done)
            state_reg <= dmsc_pkg::ST_CLOSING;
        dmsc_pkg::ST_CLOSING:
          if (mode == dmsc_pkg::MODE_OPEN || (mode == dmsc_pkg::MODE_AUTO && busy))
            state_reg <= dmsc_pkg::ST_OPENING;
          else if (sense_s.at_closed)
            state_reg <= dmsc_pkg::ST_CLOSED;
        dmsc_pkg::ST_TEACH_STOP:
          state_reg <= dmsc_pkg::ST_CLOSING;
        default:
          state_reg <= dmsc_pkg::ST_CLOSING;
      endcase
    end
  end

  // Commands lag the state by one cycle so every output is a flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drive_cmd    <= '{open: 1'b0, close: 1'b0, creep: 1'b0, stop: 1'b1};
      drive_target <= '0;
    end
    else
    begin
      drive_cmd.open  <= (state_reg == dmsc_pkg::ST_OPENING);
      drive_cmd.close <= (state_reg == dmsc_pkg::ST_CLOSING);
      drive_cmd.creep <= (mode == dmsc_pkg::MODE_OPEN);
      drive_cmd.stop  <= (state_reg != dmsc_pkg::ST_OPENING) &&
                         (state_reg != dmsc_pkg::ST_CLOSING);
      drive_target    <= target;
    end
  end
endmodule
`default_nettype wire

// [verif/dmsc_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module dmsc_checker (
  // Clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Bus handshakes
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  // Door side
  input wire dmsc_pkg::dmsc_panel_t      panel_pin,
  input wire dmsc_pkg::dmsc_sense_t      sense_pin,
  input wire dmsc_pkg::dmsc_cmd_t        drive_cmd,
  input wire logic [dmsc_pkg::POS_W-1:0] drive_target
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Selector decode, pins pass a two-stage sync so windows allow for it
  wire logic md_open  = panel_pin.present && panel_pin.main_sel == dmsc_pkg::SEL_OPEN;
  wire logic md_close = panel_pin.present && panel_pin.main_sel == dmsc_pkg::SEL_CLOSE;
  wire logic ext_only = panel_pin.present && panel_pin.main_sel == dmsc_pkg::SEL_AUTO
                        && panel_pin.exit_only && sense_pin.at_closed && !sense_pin.act_int;
  // ==========
  // Door modes
  property p_creep;
    md_open[*6] |-> drive_cmd.creep;
  endproperty
  a_creep: assert property (p_creep) else $error("no creep in open mode");
  property p_full;
    (md_open && panel_pin.partial)[*6] |-> drive_target == dmsc_pkg::FULL_POS;
  endproperty
  a_full: assert property (p_full) else $error("partial width used in open");
  property p_shut;
    (md_close && sense_pin.at_open)[*3] |-> ##[0:3] drive_cmd.close;
  endproperty
  a_shut: assert property (p_shut) else $error("open door not closed");
  property p_noopen;
    md_close[*6] |-> !drive_cmd.open;
  endproperty
  a_noopen: assert property (p_noopen) else $error("opening in closed mode");
  property p_nopanel;
    (!panel_pin.present)[*6] |-> !drive_cmd.open;
  endproperty
  a_nopanel: assert property (p_nopanel) else $error("opening without panel");
  // A late internal request clears ext_only through act_int inside the run, so it stays vacuous
  property p_ext;
    (ext_only && !drive_cmd.open)[*8] |=> !drive_cmd.open;
  endproperty
  a_ext: assert property (p_ext) else $error("external request opened door");
  // ==========
  // Bus answers
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_wr;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write response repeated");
endmodule
bind dmsc_top dmsc_checker chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .panel_pin, .sense_pin, .drive_cmd,
  .drive_target);
`default_nettype wire

// [verif/dmsc_door_model.sv]
`timescale 1ns/1ns
`default_nettype none
module dmsc_door_model (
  // Clock
  input  wire logic                       aclk,
  // Drive commands
  input  wire dmsc_pkg::dmsc_cmd_t        cmd,
  // Position and end switches
  output var  logic [dmsc_pkg::POS_W-1:0] pos,
  output var  logic                       at_closed,
  output var  logic                       at_open
);
  // ==========
  // Travel, creep is slow so a teach can catch a mid position
  logic [16:0] step;
  initial pos = 16'h0000;
  assign step = cmd.creep ? 17'h00100 : 17'h00800;
  always @(posedge aclk)
  begin
    if (!cmd.stop && cmd.open)
      pos <= (17'(pos) + step > 17'h0FFFF) ? 16'hFFFF : pos + step[15:0];
    else if (!cmd.stop && cmd.close)
      pos <= (17'(pos) < step) ? 16'h0000 : pos - step[15:0];
  end
  assign at_closed = (pos == 16'h0000);
  assign at_open   = (pos == 16'hFFFF);
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ==========
  // Signals
  logic                  aclk          = 1'b0;
  logic                  aresetn       = 1'b0;
  logic [7:0]            s_axi_awaddr  = 8'h00;
  logic [7:0]            s_axi_araddr  = 8'h00;
  logic                  s_axi_awvalid = 1'b0;
  logic                  s_axi_wvalid  = 1'b0;
  logic                  s_axi_bready  = 1'b0;
  logic                  s_axi_arvalid = 1'b0;
  logic                  s_axi_rready  = 1'b0;
  logic [31:0]           s_axi_wdata   = 32'h0;
  logic [3:0]            s_axi_wstrb   = 4'hF;
  logic [31:0]           s_axi_rdata;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  dmsc_pkg::dmsc_panel_t panel_pin     = 5'h00;
  dmsc_pkg::dmsc_sense_t sense_pin;
  dmsc_pkg::dmsc_cmd_t   drive_cmd;
  logic [15:0]           door_pos, drive_target, pw;
  logic                  ai = 1'b0, ae = 1'b0, pr = 1'b0, bm = 1'b0, at_c, at_o;
  logic [31:0]           d;
  logic [1:0]            r;
  int                    num_errors = 0, comparisons = 0, cyc = 0;
  assign sense_pin = {ai, ae, pr, bm, at_c, at_o};
  always #20 aclk = ~aclk;
  dmsc_top #(.TEACH_WIN_CYC(50), .MS_CYC(4)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .panel_pin, .sense_pin,
    .door_pos, .drive_cmd, .drive_target);
  dmsc_door_model door (.aclk, .cmd(drive_cmd), .pos(door_pos), .at_closed(at_c), .at_open(at_o));
  // ==========
  // Helpers
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic pan(input logic [1:0] m, input logic x, input logic p, input logic s);
    panel_pin <= {m, x, p, s};
  endtask
  task automatic till(input bit op);
    for (int i = 0; i < 3000 && (op ? at_o : at_c) !== 1'b1; i++) @(posedge aclk);
    chk((op ? at_o : at_c) === 1'b1, "door travel timeout");
  endtask
  task automatic upto(input logic [15:0] p);
    for (int i = 0; i < 3000 && door_pos < p; i++) @(posedge aclk);
    chk(door_pos >= p, "door short of position");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // ==========
  // Scenarios
  task automatic t_regs;
    rd(8'h0C); chk(d[18:16] === 3'h0 && d[21:20] === 2'h1, "status no panel");
    rd(8'h04); chk(d[15:0] === dmsc_pkg::HOLD_RST && r === 2'h0, "hold reset");
    wr(8'h04, 32'h2);
    rd(8'h04); chk(d[15:0] === 16'h0002, "hold write");
    rd(8'h40); chk(r === dmsc_pkg::RESP_SLVERR && d === 32'h0, "unmapped read");
    wr(8'h40, 32'h1); chk(r === dmsc_pkg::RESP_SLVERR, "unmapped write");
    rd(8'h08); chk(d[15:0] === dmsc_pkg::PWIDTH_RST, "width reset");
    pw = d[15:0];
  endtask
  task automatic t_auto;
    pan(dmsc_pkg::SEL_AUTO, 1'b0, 1'b0, 1'b1);
    pr <= 1'b1;
    bm <= 1'b1;
    ai <= 1'b1;
    cy(2);
    ai <= 1'b0;
    till(1); chk(at_o === 1'b1 && drive_target === 16'hFFFF, "full open");
    cy(40); chk(at_o === 1'b1 && drive_cmd.close === 1'b0, "held busy");
    pr <= 1'b0;
    cy(20); chk(at_o === 1'b1 && drive_cmd.close === 1'b0, "held by beam");
    bm <= 1'b0;
    cy(6); chk(drive_cmd.close === 1'b0, "hold too short");
    cy(20); chk(at_o === 1'b0, "no close after hold");
    till(0);
  endtask
  task automatic t_exit;
    pan(dmsc_pkg::SEL_AUTO, 1'b1, 1'b0, 1'b1);
    cy(4);
    ae <= 1'b1;
    cy(3);
    ae <= 1'b0;
    cy(20); chk(door_pos === 16'h0000, "external opened");
    pan(dmsc_pkg::SEL_AUTO, 1'b0, 1'b0, 1'b1);
    cy(4);
    ae <= 1'b1;
    cy(3);
    ae <= 1'b0;
    till(1); chk(at_o === 1'b1, "external ignored");
    till(0);
  endtask
  task automatic t_open;
    pan(dmsc_pkg::SEL_OPEN, 1'b0, 1'b0, 1'b1);
    cy(12); chk(drive_cmd.creep === 1'b1 && door_pos !== 16'h0, "no creep");
    pan(dmsc_pkg::SEL_CLOSE, 1'b0, 1'b0, 1'b1);
    cy(6); chk(drive_cmd.close === 1'b1, "no reverse");
    till(0);
    cy(30); chk(at_c === 1'b1, "left closed");
    pan(dmsc_pkg::SEL_OPEN, 1'b0, 1'b1, 1'b1);
    till(1);
    cy(30); chk(at_o === 1'b1 && drive_target === 16'hFFFF, "open width");
    pan(dmsc_pkg::SEL_CLOSE, 1'b0, 1'b0, 1'b1);
    cy(6); chk(drive_cmd.close === 1'b1, "no close");
    till(0);
    pan(dmsc_pkg::SEL_OPEN, 1'b0, 1'b0, 1'b1);
    cy(20);
    pan(dmsc_pkg::SEL_OPEN, 1'b0, 1'b0, 1'b0);
    till(0); chk(at_c === 1'b1, "panel lost");
    pan(2'h3, 1'b0, 1'b0, 1'b1);
    cy(20); chk(at_c === 1'b1 && drive_cmd.open === 1'b0, "code 3 moved door");
  endtask
  task automatic t_teach;
    pan(dmsc_pkg::SEL_OPEN, 1'b0, 1'b0, 1'b1);
    upto(16'h3000);
    pan(dmsc_pkg::SEL_AUTO, 1'b0, 1'b1, 1'b1);
    pw = door_pos;
    for (int i = 0; i < 20 && drive_cmd.close !== 1'b1; i++) @(posedge aclk);
    chk(drive_cmd.close === 1'b1, "no close after teach");
    rd(8'h08); chk(d[15:0] >= pw && d[15:0] <= pw + 16'h0800, "capture");
    pw = d[15:0];
    rd(8'h10); chk(d[0] === 1'b1, "taught flag");
    till(0);
    ai <= 1'b1;
    cy(2);
    ai <= 1'b0;
    upto(pw);
    cy(3);
    chk(door_pos < pw + 16'h2000 && at_o === 1'b0 && drive_cmd.stop === 1'b1, "partial stop");
    chk(drive_target === pw, "partial target");
    till(0);
  endtask
  task automatic t_miss;
    pan(dmsc_pkg::SEL_OPEN, 1'b0, 1'b0, 1'b1);
    upto(16'h2000);
    pan(dmsc_pkg::SEL_AUTO, 1'b0, 1'b0, 1'b1);
    cy(80);
    pan(dmsc_pkg::SEL_AUTO, 1'b0, 1'b1, 1'b1);
    cy(10);
    rd(8'h10); chk(d[1] === 1'b1, "missed flag");
    wr(8'h10, 32'h3);
    rd(8'h10); chk(d[1:0] === 2'h0, "flags not cleared");
    rd(8'h08); chk(d[15:0] === pw, "width moved");
    pan(dmsc_pkg::SEL_AUTO, 1'b0, 1'b0, 1'b1);
    till(0);
    wr(8'h00, 32'h1);
    pan(dmsc_pkg::SEL_OPEN, 1'b0, 1'b0, 1'b1);
    upto(16'h2000);
    pan(dmsc_pkg::SEL_AUTO, 1'b0, 1'b1, 1'b1);
    cy(10);
    rd(8'h08); chk(d[15:0] === pw, "teach not locked");
    pan(dmsc_pkg::SEL_AUTO, 1'b0, 1'b0, 1'b1);
    till(0);
  endtask
  // ==========
  // Run control
  task automatic complete_run;
    $display("Errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    cy(10);
    aresetn <= 1'b1;
    cy(4);
    t_regs();
    t_auto();
    t_exit();
    t_open();
    t_teach();
    t_miss();
    complete_run();
  end
endmodule
`default_nettype wire
